// ===== pot_bus_pkg.sv
// -----------------------------------------------------------------------------
// Shared constants and types of the wiper command slave
// -----------------------------------------------------------------------------
package pot_bus_pkg;

    // -------------------------------------------------------------------------
    // Addresses on the serial bus
    // -------------------------------------------------------------------------
    localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;  // Shared by every device.
    localparam logic [3:0] WIPER0_LOC        = 4'h0;   // Volatile wiper 0.
    localparam logic [3:0] WIPER1_LOC        = 4'h1;   // Volatile wiper 1.

    // -------------------------------------------------------------------------
    // Command byte field positions
    // -------------------------------------------------------------------------
    localparam int CMD_LOC_MSB = 7;  // Memory location, upper nibble.
    localparam int CMD_LOC_LSB = 4;
    localparam int CMD_OP_MSB  = 3;  // Operation code.
    localparam int CMD_OP_LSB  = 2;
    localparam int CMD_DHI_MSB = 1;  // Data bits 9:8 of a write.
    localparam int CMD_DHI_LSB = 0;

    // -------------------------------------------------------------------------
    // Wiper scale points and reset values
    // -------------------------------------------------------------------------
    localparam logic [9:0] ZERO_SCALE      = 10'h000;
    localparam logic [9:0] FULL_SCALE_8BIT = 10'h100;
    localparam logic [9:0] FULL_SCALE_7BIT = 10'h080;
    localparam logic [9:0] MID_SCALE_8BIT  = 10'h080;  // Power-on value, 8-bit.
    localparam logic [9:0] MID_SCALE_7BIT  = 10'h040;  // Power-on value, 7-bit.

    // -------------------------------------------------------------------------
    // Bit counting and pin synchroniser
    // -------------------------------------------------------------------------
    localparam logic [3:0] BYTE_BITS   = 4'h8;  // Bits of a byte before its ack.
    localparam logic [3:0] LAST_TX_BIT = 4'h7;  // Index of the last bit driven.
    localparam int         PIN_COUNT   = 4;     // scl, sda, address bit, hv level.

    // Operation codes in command bits 3:2, in encoding order.
    typedef enum logic [1:0] {OP_WRITE, OP_INC, OP_DEC, OP_READ} op_t;

    // Interface state machine phases.
    typedef enum logic [2:0] {PH_IDLE, PH_RX, PH_ACK, PH_TX, PH_TXACK} phase_t;

    // What the byte being received means.
    typedef enum logic [1:0] {KIND_CTRL, KIND_CMD, KIND_DATA, KIND_TX} kind_t;

endpackage : pot_bus_pkg

// ===== bus_events_if.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------------------
// Cleaned pin levels and bus events, from sampler to command logic
// -----------------------------------------------------------------------------
interface bus_events_if;
    logic scl_rise;  // One-cycle pulse, clean scl rose.
    logic scl_fall;  // One-cycle pulse, clean scl fell.
    logic start;     // One-cycle pulse, sda fell while scl high.
    logic stop;      // One-cycle pulse, sda rose while scl high.
    logic sda;       // Clean sda level.
    logic a0;        // Clean address select bit 0 level.
    logic hv;        // Clean high-voltage detect level.

    modport sampler (output scl_rise, scl_fall, start, stop, sda, a0, hv);
    modport user    (input  scl_rise, scl_fall, start, stop, sda, a0, hv);
endinterface : bus_events_if

// ===== bus_sampler.sv
`timescale 1ns/10ps
// -----------------------------------------------------------------------------
// Pin synchroniser and bus condition detector
// -----------------------------------------------------------------------------
module bus_sampler
    import pot_bus_pkg::*;
(
    // Clock and reset.
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // Raw pins: {hv, a0, sda, scl}.
    input  wire logic [PIN_COUNT-1:0] pins,
    // Cleaned levels and events.
    bus_events_if.sampler             ev
);
    import pot_bus_pkg::*;

    // All state of the sampler.
    typedef struct packed {
        logic [PIN_COUNT-1:0] s1;     // First stage, read only by s2.
        logic [PIN_COUNT-1:0] s2;     // Second stage.
        logic [PIN_COUNT-1:0] s3;     // Third stage.
        logic [PIN_COUNT-1:0] clean;  // Accepted level.
        logic [3:0]           pulse;  // {stop, start, fall, rise}.
    } samp_t;

    samp_t st;       // Registered state.
    samp_t next_st;  // Next state.

    // -------------------------------------------------------------------------
    // Next state: a level is accepted once stages two and three agree
    // -------------------------------------------------------------------------
    always_comb begin
        next_st    = st;
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // A change shorter than two clocks is filtered out as a glitch.
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.clean[i] = st.s3[i];
            end
        end
        // Edges of clean scl, and sda moves while clean scl stays high.
        next_st.pulse[0] = !st.clean[0] && next_st.clean[0];
        next_st.pulse[1] = st.clean[0] && !next_st.clean[0];
        next_st.pulse[2] = st.clean[0] && next_st.clean[0] && st.clean[1] && !next_st.clean[1];
        next_st.pulse[3] = st.clean[0] && next_st.clean[0] && !st.clean[1] && next_st.clean[1];
    end

    // -------------------------------------------------------------------------
    // State register; an idle bus is high on both lines
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '{s1: 4'h3, s2: 4'h3, s3: 4'h3, clean: 4'h3, pulse: 4'h0};
        end else begin
            st <= next_st;
        end
    end

    assign ev.scl_rise = st.pulse[0];
    assign ev.scl_fall = st.pulse[1];
    assign ev.start    = st.pulse[2];
    assign ev.stop     = st.pulse[3];
    assign ev.sda      = st.clean[1];
    assign ev.a0       = st.clean[2];
    assign ev.hv       = st.clean[3];

endmodule : bus_sampler

// ===== wiper_cmd_slave.sv
`timescale 1ns/10ps
// What this block does
// - Decrement valid only at locations 00h, 01h
// - Decrement by one, saturating at 000h
// - Device drives ack for every byte of an addressed, valid command
// - Command string ends at Stop; mixing allowed
// - Wiper updates right after each command ack
// - High-voltage qualifier read from shared pin
// - Software reset clears interface, keeps wipers
// - Any Start resets the interface machine
// - Master not-ack after sent byte resets
// - Stop after reset sequence never writes
// - After Stop stay idle until Start
// - Act on general call inc, dec, write
// - Invalid command: release, ignore until Start
// - Full scale 100h or 80h per variant
// - Master not-ack aborts and frees bus
module wiper_cmd_slave
    import pot_bus_pkg::*;
#(
    parameter int         WIPER_BITS = 8,      // Resolution variant, 7 or 8.
    parameter logic [5:0] ADDR_HI    = 6'h16   // Address bits 6:1, strap value.
) (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       rst,
    // Serial bus pins.
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // Shared address and high-voltage pin, as logic level and detector output.
    input  wire logic       address_select_bit0,
    input  wire logic       high_voltage_qualifier_pin,
    // Wiper settings and mode.
    output logic [9:0]      wiper0,
    output logic [9:0]      wiper1,
    output logic            hv_command_mode
);
    import pot_bus_pkg::*;

    // -------------------------------------------------------------------------
    // Variant checks and scale points
    // -------------------------------------------------------------------------
    if (WIPER_BITS != 7 && WIPER_BITS != 8) begin : g_bad_bits
        $error("WIPER_BITS must be 7 or 8");
    end

    localparam logic [9:0] FULL_SCALE = (WIPER_BITS == 8) ? FULL_SCALE_8BIT
                                                          : FULL_SCALE_7BIT;
    localparam logic [9:0] MID_SCALE  = (WIPER_BITS == 8) ? MID_SCALE_8BIT
                                                          : MID_SCALE_7BIT;

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    // New wiper value for one operation; reads and unknown ops leave it alone.
    function automatic logic [9:0] apply_op(op_t op, logic [9:0] w, logic [9:0] data);
        logic [9:0] r;
        r = w;
        unique case (op)
            OP_WRITE: r = data;
            OP_INC:   r = (w < FULL_SCALE) ? w + 10'h001 : w;
            // Reserved values above full scale and zero stay put.
            OP_DEC:   r = (w != ZERO_SCALE && w <= FULL_SCALE) ? w - 10'h001 : w;
            OP_READ:  r = w;
        endcase
        return r;
    endfunction : apply_op

    // Only the two volatile wipers exist; a read makes no sense on general call.
    function automatic logic cmd_valid(logic [3:0] loc, op_t op, logic gc);
        return (loc == WIPER0_LOC || loc == WIPER1_LOC) && !(gc && op == OP_READ);
    endfunction : cmd_valid

    // Byte sent on a read: bits 9:8 first, then bits 7:0.
    function automatic logic [7:0] tx_byte(logic low, logic [9:0] w);
        return low ? w[7:0] : {6'h00, w[9:8]};
    endfunction : tx_byte

    // -------------------------------------------------------------------------
    // Pin sampling
    // -------------------------------------------------------------------------
    bus_events_if ev ();

    bus_sampler u_sampler (
        .mclk (mclk),
        .rst  (rst),
        .pins ({high_voltage_qualifier_pin, address_select_bit0, sda_in, scl_in}),
        .ev   (ev.sampler)
    );

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    typedef struct packed {
        phase_t          phase;    // Interface machine phase.
        kind_t           kind;     // Meaning of the current byte.
        logic [3:0]      bitcnt;   // Bits handled in the current byte.
        logic [7:0]      shreg;    // Received or outgoing byte.
        logic            drv;      // Pull sda low.
        op_t             pend;     // Operation to apply at the end of ack.
        logic            pend_go;  // An operation waits for the ack to end.
        logic [3:0]      ptr;      // Last addressed location.
        logic [1:0]      dhi;      // Data bits 9:8 of a pending write.
        logic            gcall;    // Transfer uses the general call address.
        logic            hv_mode;  // Transfer runs in high-voltage mode.
        logic            txlow;    // Next byte sent is the low byte.
        logic [1:0][9:0] wiper;    // Volatile wiper settings.
    } slave_t;

    slave_t st;       // Registered state.
    slave_t next_st;  // Next state.

    // -------------------------------------------------------------------------
    // Interface state machine
    // -------------------------------------------------------------------------
    always_comb begin
        logic [3:0] loc;
        op_t        op;
        loc     = st.shreg[CMD_LOC_MSB:CMD_LOC_LSB];
        op      = op_t'(st.shreg[CMD_OP_MSB:CMD_OP_LSB]);
        next_st = st;
        if (ev.stop) begin
            // Stop ends everything; nothing pending survives, so a Stop that
            // lands in an ack of a broken transfer cannot write.
            next_st.phase   = PH_IDLE;
            next_st.drv     = 1'b0;
            next_st.pend_go = 1'b0;
        end else if (ev.start) begin
            // A Start restarts the machine from any phase; wipers are kept.
            next_st.phase   = PH_RX;
            next_st.kind    = KIND_CTRL;
            next_st.bitcnt  = 4'h0;
            next_st.drv     = 1'b0;
            next_st.pend_go = 1'b0;
        end else begin
            unique case (st.phase)
                // Idle and ignored transfers alike wait for the next Start.
                PH_IDLE: ;
                PH_RX: begin
                    if (ev.scl_rise) begin
                        next_st.shreg  = {st.shreg[6:0], ev.sda};
                        next_st.bitcnt = st.bitcnt + 4'h1;
                    end else if (ev.scl_fall && st.bitcnt == BYTE_BITS) begin
                        next_st.phase = PH_ACK;
                        next_st.drv   = 1'b1;
                        unique case (st.kind)
                            KIND_CTRL: begin
                                next_st.gcall   = st.shreg[7:1] == GENERAL_CALL_ADDR
                                                  && !st.shreg[0];
                                next_st.hv_mode = ev.hv;
                                next_st.txlow   = 1'b0;
                                next_st.kind    = st.shreg[0] ? KIND_TX : KIND_CMD;
                                if (st.shreg[7:1] != {ADDR_HI, ev.a0} && !next_st.gcall) begin
                                    next_st.phase = PH_IDLE;  // Not for us.
                                    next_st.drv   = 1'b0;
                                end
                            end
                            KIND_CMD: begin
                                if (!cmd_valid(loc, op, st.gcall)) begin
                                    next_st.phase = PH_IDLE;
                                    next_st.drv   = 1'b0;
                                end else begin
                                    next_st.ptr = loc;
                                    if (op == OP_WRITE) begin
                                        next_st.kind = KIND_DATA;
                                        next_st.dhi  = st.shreg[CMD_DHI_MSB:CMD_DHI_LSB];
                                    end else if (op != OP_READ) begin
                                        next_st.pend    = op;
                                        next_st.pend_go = 1'b1;
                                    end
                                end
                            end
                            KIND_DATA: begin
                                next_st.pend    = OP_WRITE;
                                next_st.pend_go = 1'b1;
                                next_st.kind    = KIND_CMD;
                            end
                            default: begin
                                next_st.phase = PH_IDLE;
                                next_st.drv   = 1'b0;
                            end
                        endcase
                    end
                end
                PH_ACK: begin
                    // The wiper moves as the ack clock ends, byte by byte.
                    if (ev.scl_fall) begin
                        next_st.drv     = 1'b0;
                        next_st.bitcnt  = 4'h0;
                        next_st.pend_go = 1'b0;
                        next_st.phase   = PH_RX;
                        if (st.pend_go) begin
                            next_st.wiper[st.ptr[0]] = apply_op(st.pend, st.wiper[st.ptr[0]],
                                                                {st.dhi, st.shreg});
                        end
                        if (st.kind == KIND_TX) begin
                            next_st.phase = PH_TX;
                            next_st.shreg = tx_byte(st.txlow, st.wiper[st.ptr[0]]);
                            next_st.drv   = !next_st.shreg[7];
                            next_st.txlow = !st.txlow;
                        end
                    end
                end
                PH_TX: begin
                    if (ev.scl_fall) begin
                        if (st.bitcnt == LAST_TX_BIT) begin
                            next_st.drv   = 1'b0;
                            next_st.phase = PH_TXACK;
                        end else begin
                            next_st.bitcnt = st.bitcnt + 4'h1;
                            next_st.shreg  = {st.shreg[6:0], 1'b0};
                            next_st.drv    = !st.shreg[6];
                        end
                    end
                end
                PH_TXACK: begin
                    if (ev.scl_rise && ev.sda) begin
                        next_st.phase = PH_IDLE;
                    end else if (ev.scl_fall) begin
                        next_st.phase  = PH_TX;
                        next_st.bitcnt = 4'h0;
                        next_st.shreg  = tx_byte(st.txlow, st.wiper[st.ptr[0]]);
                        next_st.drv    = !next_st.shreg[7];
                        next_st.txlow  = !st.txlow;
                    end
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // State register; only power-on reset touches the wipers
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st       <= '0;
            st.wiper <= {MID_SCALE, MID_SCALE};
        end else begin
            st <= next_st;
        end
    end

    assign sda_out         = 1'b0;  // Open drain: the pin is only ever pulled low.
    assign sda_oe_n        = !st.drv;
    assign wiper0          = st.wiper[0];
    assign wiper1          = st.wiper[1];
    assign hv_command_mode = st.hv_mode;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic ack_end;  // Last cycle of an ack slot.
    assign ack_end = st.phase == PH_ACK && ev.scl_fall && !ev.stop && !ev.start;

    chk_dec_step: assert property (ack_end && st.pend_go && st.pend == OP_DEC
        && st.wiper[st.ptr[0]] != ZERO_SCALE && st.wiper[st.ptr[0]] <= FULL_SCALE
        |=> st.wiper[$past(st.ptr[0])] == $past(st.wiper[st.ptr[0]]) - 10'h001)
        else $error("decrement did not lower wiper by one");
    chk_dec_floor: assert property (ack_end && st.pend_go && st.pend == OP_DEC
        && st.wiper[st.ptr[0]] == ZERO_SCALE |=> st.wiper[$past(st.ptr[0])] == ZERO_SCALE)
        else $error("decrement went below zero");
    chk_dec_reserved: assert property (ack_end && st.pend_go && st.pend == OP_DEC
        && st.wiper[st.ptr[0]] > FULL_SCALE |=> $stable(st.wiper))
        else $error("reserved wiper value was decremented");
    chk_wiper_only_ack: assert property (!ack_end |=> $stable(st.wiper))
        else $error("wiper changed outside an ack end");
    chk_ack_driven: assert property (st.phase == PH_ACK |-> !sda_oe_n)
        else $error("ack slot not driven");
    chk_start_resets: assert property (ev.start && !ev.stop
        |=> st.phase == PH_RX && st.bitcnt == 4'h0 && sda_oe_n)
        else $error("start did not restart the machine");
    chk_stop_idles: assert property (ev.stop |=> st.phase == PH_IDLE && sda_oe_n
        ##1 (st.phase == PH_IDLE || $past(ev.start)))
        else $error("stop did not idle the machine");
    chk_nak_release: assert property (st.phase == PH_TXACK && ev.scl_rise && ev.sda
        && !ev.start && !ev.stop |=> st.phase == PH_IDLE && sda_oe_n)
        else $error("not-ack did not release the bus");
    chk_bad_cmd_release: assert property (st.phase == PH_RX && st.kind == KIND_CMD
        && ev.scl_fall && st.bitcnt == BYTE_BITS && !ev.start && !ev.stop
        && !cmd_valid(st.shreg[7:4], op_t'(st.shreg[3:2]), st.gcall)
        |=> st.phase == PH_IDLE && sda_oe_n)
        else $error("invalid command was not ignored");

    cov_dec_step: cover property (ack_end && st.pend_go && st.pend == OP_DEC);
    cov_gcall_cmd: cover property (ack_end && st.gcall && st.pend_go);
    cov_read_nak: cover property (st.phase == PH_TXACK && ev.scl_rise && ev.sda);
    cov_hv_mode: cover property (ack_end && st.hv_mode);

endmodule : wiper_cmd_slave

// ===== bus_master.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Serial bus master model
// ------------------------------------------------------------
module bus_master (
    // Clock.
    input  wire logic mclk,
    // Wired data line.
    input  wire logic sda,
    // Driven lines; sda_m high means released.
    output logic      scl,
    output logic      sda_m,
    output logic      hv
);
    // The bus idles high with no qualifier.
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
        hv    = 1'b0;
    end
    // Moves both lines after an edge and holds them for eight clocks.
    task automatic phase(input logic c, input logic d);
        @(posedge mclk);
        scl   <= c;
        sda_m <= d;
        repeat (7) @(posedge mclk);
    endtask : phase
    // The clock stays still for a while after the qualifier moves.
    task automatic set_hv(input logic v);
        @(posedge mclk);
        hv <= v;
        repeat (16) @(posedge mclk);
    endtask : set_hv
    // Start, also the second Start that ends a recovery.
    task automatic start();
        phase(1'b0, sda_m);
        phase(1'b0, 1'b1);
        phase(1'b1, 1'b1);
        phase(1'b1, 1'b0);
    endtask : start
    // Stop ends every command string.
    task automatic stop();
        phase(1'b0, sda_m);
        phase(1'b0, 1'b0);
        phase(1'b1, 1'b0);
        phase(1'b1, 1'b1);
    endtask : stop
    // One bit; returns the wire level late in the high phase.
    task automatic send_bit(input logic b, output logic s);
        phase(1'b0, sda_m);
        phase(1'b0, b);
        phase(1'b1, b);
        s = sda;
    endtask : send_bit
    // Eight bits MSB first, then the ack slot with sda released.
    task automatic send_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            send_bit(d[i], ack);
        end
        send_bit(1'b1, ack);
    endtask : send_byte
endmodule : bus_master

// ===== testbench.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Bench: master model drives, a monitor takes queued notes
// ------------------------------------------------------------
module testbench;
    import pot_bus_pkg::*;
    logic        mclk  = 1'b0;
    logic        rst   = 1'b1;
    logic        drove = 1'b0;  // Set whenever the device pulls sda.
    logic        scl, sda_m, hv, sda_out, sda_oe_n, hv_mode, a;
    logic [9:0]  wiper0, wiper1, p0, p1;
    logic [7:0]  r;
    logic [10:0] notes[$];      // Expected {wiper select, value}, oldest first.
    int          num_errors      = 0;
    int          samples_checked = 0;
    int          cycles          = 0;
    int          seed            = 32'hdf27;
    wire         sda = sda_m & (sda_oe_n | sda_out);  // Pull-up when released.
    always #10 mclk = ~mclk;
    bus_master u_master (.mclk(mclk), .sda(sda), .scl(scl), .sda_m(sda_m), .hv(hv));
    // The shared pin reads as a logic one while it is held at the high level.
    wiper_cmd_slave u_dut (.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_select_bit0(hv),
        .high_voltage_qualifier_pin(hv), .wiper0(wiper0), .wiper1(wiper1),
        .hv_command_mode(hv_mode));
    task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic stop_test();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    // A wiper change with no note left meets an unknown and fails.
    always @(negedge mclk) begin
        if (!rst && (wiper0 !== p0 || wiper1 !== p1)) begin
            check("wiper", notes.size() > 0 ? notes.pop_front() : 11'bx,
                  (wiper1 !== p1) ? {1'b1, wiper1} : {1'b0, wiper0});
        end
        drove = drove | ~sda_oe_n;
        p0 = wiper0;
        p1 = wiper1;
    end
    // Hang guard, well above the length of the run.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            stop_test();
        end
    end
    // One byte and its ack; nt[11] marks a wiper change due after the ack.
    task automatic xfer(input logic [7:0] b, input logic na, input logic [11:0] nt);
        if (nt[11]) begin
            notes.push_back(nt[10:0]);
        end
        u_master.send_byte(b, a);
        check("ack", {10'h0, na}, {10'h0, a});
        u_master.phase(1'b0, sda_m);
        u_master.phase(1'b0, sda_m);
        check("late update", 11'h0, 11'(notes.size()));
    endtask : xfer
    // A byte during which the device must leave sda alone.
    task automatic quiet(input logic [7:0] b);
        drove = 1'b0;
        u_master.send_byte(b, a);
        check("sda driven", 11'h0, {10'h0, drove});
    endtask : quiet
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        check("reset wiper1", {1'b1, MID_SCALE_8BIT}, {1'b1, wiper1});
        u_master.set_hv(1'b1);
        u_master.start();
        xfer(8'h5a, 1'b0, 12'h000);
        check("hv mode", 11'h1, {10'h0, hv_mode});
        xfer(8'h18, 1'b0, 12'hc7f);
        xfer(8'h08, 1'b0, 12'h87f);
        xfer(8'h00, 1'b0, 12'h000);
        xfer(8'h01, 1'b0, 12'h801);
        xfer(8'h08, 1'b0, 12'h800);
        xfer(8'h08, 1'b0, 12'h000);
        u_master.stop();
        u_master.set_hv(1'b0);
        r = 8'($random(seed));
        u_master.start();
        xfer(8'h58, 1'b0, 12'h000);
        check("hv mode", 11'h0, {10'h0, hv_mode});
        xfer(8'h00, 1'b0, 12'h000);
        xfer(r, 1'b0, {r != 8'h00, 3'b000, r});
        xfer(8'h08, 1'b0, {r != 8'h00, 3'b000, r - 8'h01});
        xfer(8'h13, 1'b0, 12'h000);
        xfer(8'hff, 1'b0, 12'hfff);
        xfer(8'h18, 1'b0, 12'h000);
        xfer(8'h11, 1'b0, 12'h000);
        xfer(8'h00, 1'b0, 12'hd00);
        xfer(8'h18, 1'b0, 12'hcff);
        xfer(8'h28, 1'b1, 12'h000);
        quiet(8'h18);
        u_master.stop();
        quiet(8'h58);
        u_master.start();
        xfer(8'h00, 1'b0, 12'h000);
        xfer(8'h18, 1'b0, 12'hcfe);
        xfer(8'h00, 1'b0, 12'h000);
        for (int i = 0; i < 4; i++) u_master.send_bit(1'b0, a);
        u_master.start();
        for (int i = 0; i < 9; i++) u_master.send_bit(1'b1, a);
        u_master.start();
        u_master.stop();
        u_master.start();
        xfer(8'h58, 1'b0, 12'h000);
        xfer(8'h18, 1'b0, 12'hcfd);
        u_master.start();
        xfer(8'h59, 1'b0, 12'h000);
        u_master.send_byte(8'hff, a);
        check("nak seen", 11'h1, {10'h0, a});
        quiet(8'hff);
        u_master.stop();
        repeat (20) @(posedge mclk);
        check("notes left", 11'h0, 11'(notes.size()));
        stop_test();
    end
endmodule : testbench
